// ==== rtl/ums_pkg.sv ====
// Constants, carriers and state layout for the modem-status and scratch channel block
package ums_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned AXI_ADDR_W = 6;
   localparam int unsigned IDX_W = 4;
   // Register word indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_DATA = 4'h0;
   localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 4'h1;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 4'h2;
   localparam logic [IDX_W-1:0] IDX_LINE_CONTROL = 4'h3;
   localparam logic [IDX_W-1:0] IDX_MODEM_CONTROL = 4'h4;
   localparam logic [IDX_W-1:0] IDX_LINE_STATUS = 4'h5;
   localparam logic [IDX_W-1:0] IDX_MODEM_STATUS = 4'h6;
   localparam logic [IDX_W-1:0] IDX_SCRATCH_PAD = 4'h7;
   // Values after reset
   localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
   localparam logic [7:0] IRQ_STATUS_RST = 8'h01;
   localparam logic [7:0] LINE_CONTROL_RST = 8'h00;
   localparam logic [7:0] MODEM_CONTROL_RST = 8'h00;
   localparam logic [7:0] LINE_STATUS_RST = 8'h60;
   localparam logic [7:0] SCRATCH_PAD_RST = 8'hff;
   localparam logic [7:0] DIVISOR_RST = 8'h00;
   localparam logic [7:0] HOLDING_RST = 8'h00;
   // Field positions
   localparam int unsigned LCR_DIV_ACCESS_BIT = 7;
   localparam int unsigned LCR_BREAK_BIT = 6;
   localparam int unsigned MCR_TERM_READY_BIT = 0;
   localparam int unsigned MCR_REQ_SEND_BIT = 1;
   localparam int unsigned MCR_AUX_ONE_BIT = 2;
   localparam int unsigned MCR_AUX_TWO_BIT = 3;
   localparam int unsigned MCR_LOOPBACK_BIT = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Active-low handshake inputs, packed so that bit order matches status bits 7..4
   typedef struct packed {
      logic carrier_in_n;
      logic bell_line_in_n;
      logic peer_ready_n;
      logic clear_to_send_n;
   } ums_modem_in_t;

   typedef struct packed {
      logic serial_out;
      logic aux_out_two_n;
      logic req_send_n;
      logic term_ready_n;
      logic irq_out;
      logic irq_oe;
   } ums_pins_out_t;

   typedef struct packed {
      ums_modem_in_t sync1;
      ums_modem_in_t sync2;
      logic [7:0] irq_enable;
      logic [7:0] line_control;
      logic [7:0] modem_control;
      logic [7:0] scratch_pad;
      logic [7:0] divisor_low;
      logic [7:0] divisor_high;
      logic [7:0] tx_holding;
      logic [15:0] baud_count;
      logic baud_tick;
      ums_pins_out_t pins;
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [IDX_W-1:0] wr_idx;
      logic [7:0] wr_data;
      logic wr_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } ums_state_t;

   localparam ums_state_t UMS_STATE_RST = '{
      sync1: 4'hf, sync2: 4'hf,
      irq_enable: IRQ_ENABLE_RST, line_control: LINE_CONTROL_RST,
      modem_control: MODEM_CONTROL_RST, scratch_pad: SCRATCH_PAD_RST,
      divisor_low: DIVISOR_RST, divisor_high: DIVISOR_RST, tx_holding: HOLDING_RST,
      baud_count: 16'h0000, baud_tick: 1'b0,
      pins: 6'h3c,
      awready: 1'b0, wready: 1'b0, aw_held: 1'b0, w_held: 1'b0,
      wr_idx: 4'h0, wr_data: 8'h00, wr_lane0: 1'b0, bvalid: 1'b0, bresp: 2'h0,
      arready: 1'b0, rvalid: 1'b0, rdata: 8'h00, rresp: 2'h0};
endpackage

// ==== rtl/ums_channel.sv ====
// One channel: register file over AXI4-Lite, modem status inputs, scratch, baud counter
// Function
// - Normal mode: status bit 4 reads inverted clear-to-send pin.
// - Normal mode: status bit 5 reads inverted peer-ready pin.
// - Normal mode: status bit 6 reads inverted ring indication pin.
// - Normal mode: status bit 7 reads inverted carrier detect pin.
// - Loopback: status bit 4 follows the request-to-send control bit.
// - Loopback: status bit 5 follows the terminal-ready control bit.
// - Loopback: status bit 6 follows modem control bit 2.
// - Loopback: status bit 7 follows modem control bit 3.
// - Scratch is 8-bit plain read/write, 0xff after reset.
// - Scratch keeps its value; only a write or reset changes it.
// - Baud generator is a 16-bit counter loaded from the divisor bytes.
// - Divisor bytes are reachable only while line control bit 7 is one.
// - Reset values: enable, line and modem control 0x00; status 0x01 and 0x60.
// - Reset: status bits 3..0 clear, bits 7..4 show inverted inputs.
// - Reset drives serial, aux two, request and ready outputs high; interrupt floats.
// - Loopback is on while modem control bit 4 is one.
// - Line control bit 7 selects divisor bytes; zero selects data registers.
module ums_channel
   import ums_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire ums_modem_in_t modem_in,
   output ums_pins_out_t pins_out,
   output logic baud_tick
);
   ums_state_t st_q;
   ums_state_t st_d;
   logic loopback;
   logic div_access;
   logic [3:0] msr_hi;
   logic [IDX_W-1:0] rd_idx;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic wr_fire;
   logic wr_mapped;

   assign loopback = st_q.modem_control[MCR_LOOPBACK_BIT];
   assign div_access = st_q.line_control[LCR_DIV_ACCESS_BIT];
   assign rd_idx = s_axi_araddr[AXI_ADDR_W-1:2];
   assign aw_take = s_axi_awvalid && st_q.awready;
   assign w_take = s_axi_wvalid && st_q.wready;
   assign ar_take = s_axi_arvalid && st_q.arready;
   assign wr_fire = st_q.aw_held && st_q.w_held && !st_q.bvalid;
   assign wr_mapped = st_q.wr_idx <= IDX_SCRATCH_PAD;

   // Upper status nibble; the synchronised pins add two cycles of lag
   always_comb begin
      if (loopback) begin
         msr_hi = {st_q.modem_control[MCR_AUX_TWO_BIT],
                   st_q.modem_control[MCR_AUX_ONE_BIT],
                   st_q.modem_control[MCR_TERM_READY_BIT],
                   st_q.modem_control[MCR_REQ_SEND_BIT]};
      end else begin
         msr_hi = ~st_q.sync2;
      end
   end

   always_comb begin
      logic [15:0] divisor;
      logic [7:0] rd_val;
      logic rd_ok;
      st_d = st_q;
      divisor = 16'h0000;
      rd_val = 8'h00;
      rd_ok = 1'b1;
      st_d.sync1 = modem_in;
      st_d.sync2 = st_q.sync1;

      // Write channel: address and data may arrive in either order
      if (aw_take) begin
         st_d.aw_held = 1'b1;
         st_d.wr_idx = s_axi_awaddr[AXI_ADDR_W-1:2];
      end
      if (w_take) begin
         st_d.w_held = 1'b1;
         st_d.wr_data = s_axi_wdata[7:0];
         st_d.wr_lane0 = s_axi_wstrb[0];
      end
      if (wr_fire) begin
         st_d.aw_held = 1'b0;
         st_d.w_held = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
         if (st_q.wr_lane0) begin
            unique case (st_q.wr_idx)
               IDX_DATA: begin
                  if (div_access) begin
                     st_d.divisor_low = st_q.wr_data;
                  end else begin
                     st_d.tx_holding = st_q.wr_data;
                  end
               end
               IDX_IRQ_ENABLE: begin
                  if (div_access) begin
                     st_d.divisor_high = st_q.wr_data;
                  end else begin
                     st_d.irq_enable = st_q.wr_data;
                  end
               end
               IDX_LINE_CONTROL: st_d.line_control = st_q.wr_data;
               IDX_MODEM_CONTROL: st_d.modem_control = st_q.wr_data;
               IDX_SCRATCH_PAD: st_d.scratch_pad = st_q.wr_data;
               // Status registers keep their value; the write is answered OKAY
               default: st_d.scratch_pad = st_q.scratch_pad;
            endcase
         end
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      st_d.awready = !st_d.aw_held && !st_d.bvalid;
      st_d.wready = !st_d.w_held && !st_d.bvalid;

      // Read channel: data is captured at the address handshake
      unique case (rd_idx)
         IDX_DATA: rd_val = div_access ? st_q.divisor_low : HOLDING_RST;
         IDX_IRQ_ENABLE: rd_val = div_access ? st_q.divisor_high : st_q.irq_enable;
         IDX_IRQ_STATUS: rd_val = IRQ_STATUS_RST;
         IDX_LINE_CONTROL: rd_val = st_q.line_control;
         IDX_MODEM_CONTROL: rd_val = st_q.modem_control;
         IDX_LINE_STATUS: rd_val = LINE_STATUS_RST;
         IDX_MODEM_STATUS: rd_val = {msr_hi, 4'h0};
         IDX_SCRATCH_PAD: rd_val = st_q.scratch_pad;
         default: rd_ok = 1'b0;
      endcase
      if (ar_take) begin
         st_d.rvalid = 1'b1;
         st_d.rdata = rd_val;
         st_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      st_d.arready = !st_d.rvalid;

      // Divide-by-N tick; a zero divisor parks the counter
      divisor = {st_q.divisor_high, st_q.divisor_low};
      st_d.baud_tick = 1'b0;
      if (divisor == 16'h0000) begin
         st_d.baud_count = 16'h0000;
      end else if (st_q.baud_count <= 16'h0001) begin
         st_d.baud_count = divisor;
         st_d.baud_tick = 1'b1;
      end else begin
         st_d.baud_count = st_q.baud_count - 16'h0001;
      end

      // Loopback disconnects the modem outputs and holds them inactive high
      st_d.pins.serial_out = st_d.modem_control[MCR_LOOPBACK_BIT]
                             || !st_d.line_control[LCR_BREAK_BIT];
      st_d.pins.aux_out_two_n = st_d.modem_control[MCR_LOOPBACK_BIT]
                                || !st_d.modem_control[MCR_AUX_TWO_BIT];
      st_d.pins.req_send_n = st_d.modem_control[MCR_LOOPBACK_BIT]
                             || !st_d.modem_control[MCR_REQ_SEND_BIT];
      st_d.pins.term_ready_n = st_d.modem_control[MCR_LOOPBACK_BIT]
                               || !st_d.modem_control[MCR_TERM_READY_BIT];
      // No interrupt source lives here, so the driven level is the idle one
      st_d.pins.irq_out = 1'b0;
      st_d.pins.irq_oe = st_d.modem_control[MCR_AUX_TWO_BIT];

      // Synchronous reset; the pin synchroniser keeps sampling through it so that
      // status bits 7..4 already show the inverted inputs when reset is released
      if (!aresetn) begin
         st_d = UMS_STATE_RST;
         st_d.sync1 = modem_in;
         st_d.sync2 = st_q.sync1;
      end
   end

   always_ff @(posedge aclk) begin
      st_q <= st_d;
   end

   assign s_axi_awready = st_q.awready;
   assign s_axi_wready = st_q.wready;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata = {24'h000000, st_q.rdata};
   assign s_axi_rresp = st_q.rresp;
   assign pins_out = st_q.pins;
   assign baud_tick = st_q.baud_tick;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_sync_clean;
      $past(aresetn) && $past(aresetn, 2);
   endsequence

   sequence s_msr_read_loop;
      ar_take && rd_idx == IDX_MODEM_STATUS && loopback;
   endsequence

   sequence s_div_read;
      ar_take && rd_idx == IDX_DATA && div_access;
   endsequence

   a_msr_cts_pin: assert property (
      (s_sync_clean and !loopback) |-> msr_hi[0] == !$past(modem_in.clear_to_send_n, 2))
      else $error("status bit 4 does not follow inverted clear-to-send");
   a_msr_ready_pin: assert property (
      (s_sync_clean and !loopback) |-> msr_hi[1] == !$past(modem_in.peer_ready_n, 2))
      else $error("status bit 5 does not follow inverted peer-ready");
   a_msr_ring_pin: assert property (
      (s_sync_clean and !loopback) |-> msr_hi[2] == !$past(modem_in.bell_line_in_n, 2))
      else $error("status bit 6 does not follow inverted ring input");
   a_msr_carrier_pin: assert property (
      (s_sync_clean and !loopback) |-> msr_hi[3] == !$past(modem_in.carrier_in_n, 2))
      else $error("status bit 7 does not follow inverted carrier input");
   a_msr_loop_read: assert property (
      s_msr_read_loop |=> s_axi_rvalid && s_axi_rdata[7:0] ==
         {$past(st_q.modem_control[3]), $past(st_q.modem_control[2]),
          $past(st_q.modem_control[0]), $past(st_q.modem_control[1]), 4'h0})
      else $error("loopback status read does not mirror modem control");
   a_reset_values: assert property (
      $past(!aresetn) |-> st_q.scratch_pad == 8'hff && st_q.line_control == 8'h00
         && st_q.modem_control == 8'h00 && st_q.irq_enable == 8'h00)
      else $error("register value after reset is wrong");
   a_scratch_hold: assert property (
      !(wr_fire && st_q.wr_lane0 && st_q.wr_idx == IDX_SCRATCH_PAD)
         |=> $stable(st_q.scratch_pad))
      else $error("scratch changed without a write");
   a_status_write_ignored: assert property (
      (wr_fire && st_q.wr_idx == IDX_MODEM_STATUS) |=> $stable({st_q.irq_enable,
         st_q.line_control, st_q.modem_control, st_q.scratch_pad,
         st_q.divisor_low, st_q.divisor_high, st_q.tx_holding}))
      else $error("modem status write altered a register");
   a_div_read_back: assert property (
      s_div_read |=> s_axi_rdata[7:0] == $past(st_q.divisor_low))
      else $error("divisor low byte not returned with access bit set");
   a_baud_reload: assert property (
      (baud_tick && $past(st_q.divisor_low) == st_q.divisor_low
         && $past(st_q.divisor_high) == st_q.divisor_high)
         |-> st_q.baud_count == {st_q.divisor_high, st_q.divisor_low})
      else $error("baud counter not reloaded from divisor at tick");
   a_pins_after_reset: assert property (
      $past(!aresetn) |-> pins_out.serial_out && pins_out.aux_out_two_n
         && pins_out.req_send_n && pins_out.term_ready_n && !pins_out.irq_oe)
      else $error("output pins not idle after reset");
   a_loop_outputs: assert property (
      loopback |-> pins_out.req_send_n && pins_out.term_ready_n)
      else $error("modem outputs active during loopback");
   a_write_answer: assert property (
      wr_fire |=> s_axi_bvalid ##0 (s_axi_bvalid throughout (!s_axi_bready [*1]))
         or s_axi_bvalid)
      else $error("write response not raised after write");

   sequence s_msr_read_pin;
      ar_take && rd_idx == IDX_MODEM_STATUS && !loopback;
   endsequence

   sequence s_div_gate_write;
      wr_fire && st_q.wr_lane0 && st_q.wr_idx == IDX_IRQ_ENABLE;
   endsequence

   // Bus side: a taken read is answered in the next cycle, a write one cycle after both halves are held
   a_read_answer: assert property (
      ar_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered one cycle after address");
   a_write_busy: assert property (
      wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
      else $error("write channels open while response pending");
   a_resp_clear: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response stays after handshake");
   a_read_clear: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data stays after handshake");
   a_rdata_upper: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data upper bytes not zero");
   a_read_unmapped: assert property (
      ar_take && rd_idx > IDX_SCRATCH_PAD |=> s_axi_rresp == RESP_SLVERR
         && s_axi_rdata == 32'h00000000)
      else $error("unmapped read not refused");
   a_write_unmapped: assert property (
      wr_fire && st_q.wr_idx > IDX_SCRATCH_PAD |=> s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");

   // Register side
   a_msr_pin_read: assert property (
      s_msr_read_pin |=> s_axi_rdata[7:0] == {~$past(modem_in, 3), 4'h0})
      else $error("normal status read does not show inverted inputs");
   a_msr_low_clear: assert property (
      ar_take && rd_idx == IDX_MODEM_STATUS |=> s_axi_rdata[3:0] == 4'h0)
      else $error("status bits 3..0 not clear");
   a_fixed_status: assert property (
      ar_take && rd_idx == IDX_LINE_STATUS |=> s_axi_rdata[7:0] == 8'h60)
      else $error("line status read is not its reset value");
   a_irq_status_read: assert property (
      ar_take && rd_idx == IDX_IRQ_STATUS |=> s_axi_rdata[7:0] == 8'h01)
      else $error("interrupt status read is not its reset value");
   a_scratch_write: assert property (
      wr_fire && st_q.wr_lane0 && st_q.wr_idx == IDX_SCRATCH_PAD
         |=> st_q.scratch_pad == $past(st_q.wr_data))
      else $error("scratch did not take the written byte");
   a_div_high_gated: assert property (
      (s_div_gate_write and !div_access) |=> $stable(st_q.divisor_high))
      else $error("divisor high written with access bit clear");
   a_irq_enable_kept: assert property (
      (s_div_gate_write and div_access) |=> $stable(st_q.irq_enable))
      else $error("interrupt enable written while divisor selected");
   a_baud_park: assert property (
      {st_q.divisor_high, st_q.divisor_low} == 16'h0000 |=> !baud_tick)
      else $error("baud tick with zero divisor");

   // Modem outputs outside loopback are the inverted control bits
   a_req_send_pin: assert property (
      !loopback |-> pins_out.req_send_n == !st_q.modem_control[MCR_REQ_SEND_BIT])
      else $error("request-to-send output does not follow its control bit");
   a_term_ready_pin: assert property (
      !loopback |-> pins_out.term_ready_n == !st_q.modem_control[MCR_TERM_READY_BIT])
      else $error("terminal-ready output does not follow its control bit");
   a_aux_two_pin: assert property (
      !loopback |-> pins_out.aux_out_two_n == !st_q.modem_control[MCR_AUX_TWO_BIT])
      else $error("aux output two does not follow its control bit");
   a_irq_float: assert property (
      !st_q.modem_control[MCR_AUX_TWO_BIT] |-> !pins_out.irq_oe)
      else $error("interrupt pin driven while disabled");
endmodule

// ==== verification/ums_modem_model.sv ====
// Behavioural modem on the handshake lines of one channel
module ums_modem_model
   import ums_pkg::*;
(
   input wire logic aclk,
   input wire logic [3:0] status_want,
   output ums_modem_in_t modem_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pins idle inactive (high) until the bench asks for an asserted line
   initial modem_in = 4'hf;
   // Asserted lines are driven low, in status bit order 7..4
   always @(posedge aclk) begin
      modem_in <= ~status_want;
   end
endmodule

// ==== verification/ums_channel_tb.sv ====
// Self-checking bench for the modem status, scratch and divisor channel
module ums_channel_tb
   import ums_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [5:0] awaddr = 6'h00;
   logic [5:0] araddr = 6'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic [3:0] want = 4'h5;
   logic awready, wready, bvalid, arready, rvalid, baud_tick;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   ums_modem_in_t modem_in;
   ums_pins_out_t pins_out;
   int fail_count = 0;
   int n_compared = 0;

   ums_channel u_ums_channel (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .modem_in(modem_in), .pins_out(pins_out),
      .baud_tick(baud_tick));
   ums_modem_model u_ums_modem_model (.aclk(aclk), .status_want(want), .modem_in(modem_in));

   initial forever #50 aclk = ~aclk;

   task automatic final_report;
      $display("fail_count=%0d n_compared=%0d", fail_count, n_compared);
      if (fail_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask

   task automatic tmo(input string nm);
      $display("mismatch %s expected handshake seen timeout", nm);
      fail_count++;
      final_report();
   endtask

   // Entered just after a rising edge; holds each channel until its own ready
   task automatic wr(input logic [3:0] i, input logic [7:0] d, input logic [3:0] s = 4'h1,
                     input logic [1:0] er = RESP_OKAY);
      int n;
      logic aw, w;
      n = 0;
      aw = 1'b1;
      w = 1'b1;
      awaddr <= {i, 2'h0};
      wdata <= {24'h0, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         n++;
         if (aw && awready) begin
            awvalid <= 1'b0;
            aw = 1'b0;
         end
         if (w && wready) begin
            wvalid <= 1'b0;
            w = 1'b0;
         end
         if (bvalid) break;
         if (n > 50) tmo("write");
      end
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge aclk);
   endtask

   task automatic rd(input logic [3:0] i, input logic [7:0] e,
                     input logic [1:0] er = RESP_OKAY);
      int n;
      logic a;
      n = 0;
      a = 1'b1;
      araddr <= {i, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         n++;
         if (a && arready) begin
            arvalid <= 1'b0;
            a = 1'b0;
         end
         if (rvalid) break;
         if (n > 50) tmo("read");
      end
      rready <= 1'b0;
      chk("rdata", {24'h0, e}, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge aclk);
   endtask

   task automatic do_reset;
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
   endtask

   // Inputs stay at status pattern 5 so the upper nibble must read 5
   task automatic t_reset;
      chk("pins", 32'h3c, {26'h0, pins_out});
      rd(IDX_IRQ_ENABLE, 8'h00);
      rd(IDX_IRQ_STATUS, 8'h01);
      rd(IDX_LINE_CONTROL, 8'h00);
      rd(IDX_MODEM_CONTROL, 8'h00);
      rd(IDX_LINE_STATUS, 8'h60);
      rd(IDX_MODEM_STATUS, 8'h50);
      rd(IDX_SCRATCH_PAD, 8'hff);
   endtask

   task automatic t_normal;
      for (int k = 0; k < 4; k++) begin
         want <= 4'(1 << k);
         repeat (4) @(posedge aclk);
         rd(IDX_MODEM_STATUS, {4'(1 << k), 4'h0});
      end
   endtask

   // Every asserted input must be hidden while the control bits drive status
   task automatic t_loop;
      logic [3:0] v;
      want <= 4'hf;
      for (int k = 0; k < 16; k++) begin
         v = 4'(k);
         wr(IDX_MODEM_CONTROL, {4'h1, v});
         rd(IDX_MODEM_STATUS, {v[3], v[2], v[0], v[1], 4'h0});
      end
      chk("pins", 32'h3d, {26'h0, pins_out});
      wr(IDX_MODEM_CONTROL, 8'h00);
      rd(IDX_MODEM_STATUS, 8'hf0);
      wr(IDX_MODEM_STATUS, 8'h00);
      rd(IDX_MODEM_STATUS, 8'hf0);
   endtask

   task automatic t_scratch;
      wr(IDX_SCRATCH_PAD, 8'h5a);
      rd(IDX_SCRATCH_PAD, 8'h5a);
      wr(IDX_SCRATCH_PAD, 8'ha5, 4'h0);
      wr(IDX_LINE_CONTROL, 8'h00);
      rd(IDX_SCRATCH_PAD, 8'h5a);
      rd(4'h8, 8'h00, RESP_SLVERR);
      wr(4'h9, 8'h11, 4'h1, RESP_SLVERR);
   endtask

   // Period 259 is long enough that an off-by-one reload shows up
   task automatic t_div;
      int n;
      wr(IDX_IRQ_ENABLE, 8'h0f);
      wr(IDX_LINE_CONTROL, 8'h80);
      wr(IDX_DATA, 8'h03);
      wr(IDX_IRQ_ENABLE, 8'h01);
      rd(IDX_DATA, 8'h03);
      rd(IDX_IRQ_ENABLE, 8'h01);
      wr(IDX_LINE_CONTROL, 8'h00);
      rd(IDX_IRQ_ENABLE, 8'h0f);
      rd(IDX_DATA, 8'h00);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (n > 600) tmo("baud tick");
      end while (baud_tick !== 1'b1);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (n > 600) tmo("baud tick");
      end while (baud_tick !== 1'b1);
      chk("baud period", 32'd259, 32'(n));
   endtask

   initial begin
      do_reset();
      t_reset();
      t_normal();
      t_loop();
      t_scratch();
      t_div();
      wr(IDX_SCRATCH_PAD, 8'h12);
      wr(IDX_MODEM_CONTROL, 8'h0b);
      chk("pins", 32'h21, {26'h0, pins_out});
      want <= 4'h5;
      do_reset();
      t_reset();
      final_report();
   end
endmodule
